// >>> core/ofcr_pkg.sv
// Package: register map, field positions and codes of the optical front end control bank
package ofcr_pkg;
  // Register byte offsets
  localparam logic [7:0] LED_RANGE_OFS = 8'h00;
  localparam logic [7:0] LED_CURR_OFS = 8'h04;
  localparam logic [7:0] PD_CFG_OFS = 8'h08;
  localparam logic [7:0] AMP_CFG_OFS = 8'h0c;
  localparam logic [7:0] MAN_SEQ_OFS = 8'h20;
  localparam logic [7:0] ITER_OFS = 8'h50;
  localparam logic [7:0] STATUS_OFS = 8'h54;

  // Writable bit masks, unlisted bits read zero except bits 23..20 at PD_CFG_OFS, which read the headroom flags
  localparam logic [31:0] LED_RANGE_MASK = 32'h0004_0fff;
  localparam logic [31:0] LED_CURR_MASK = 32'hffff_ffff;
  localparam logic [31:0] PD_CFG_MASK = 32'h0200_ff3f;
  localparam logic [31:0] AMP_CFG_MASK = 32'h8000_3fff;
  localparam logic [31:0] MAN_SEQ_MASK = 32'h04fe_3fff;

  // Reset values
  localparam logic [31:0] LED_RANGE_RST = 32'h0000_0055;
  localparam logic [31:0] LED_CURR_RST = 32'h0000_0000;
  localparam logic [31:0] PD_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] AMP_CFG_RST = 32'h0000_3f00;
  localparam logic [31:0] MAN_SEQ_RST = 32'h0000_0000;

  // Field positions
  localparam int SINK_EN_LSB = 8;
  localparam int MAN_MODE_BIT = 26;
  localparam int DIRECT_ITG_BIT = 23;
  localparam int DIRECT_LED_LSB = 19;
  localparam int ROUTING_LSB = 17;
  localparam int DMA_OFF_BIT = 13;
  localparam int SEQ_EN_BIT = 0;
  localparam int DEMOD_TRI_BIT = 25;
  localparam int HEADROOM_LSB = 20;
  localparam int OFFSET_LSB = 8;
  localparam int DIODE_LSB = 2;
  localparam int EXT_IN_LSB = 0;

  // Range codes
  localparam logic [1:0] RANGE_25MA = 2'h0;
  localparam logic [1:0] RANGE_50MA = 2'h1;
  localparam logic [1:0] RANGE_100MA = 2'h2;
  localparam logic [1:0] RANGE_RESERVED = 2'h3;

  // Diode routing codes
  typedef enum logic [1:0] {
    OFCR_ROUTE_ALL = 2'b00,
    OFCR_ROUTE_OWN = 2'b01,
    OFCR_ROUTE_PAIR_AB = 2'b10,
    OFCR_ROUTE_PAIR_AD = 2'b11
  } ofcr_route_e;

  // LED iteration mode codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_ON = 3'h1;
  localparam logic [2:0] MODE_TIMED = 3'h2;
  localparam logic [2:0] MODE_EVEN = 3'h3;
  localparam logic [2:0] MODE_ODD = 3'h4;
  localparam logic [2:0] MODE_QUARTER = 3'h5;
endpackage

// >>> core/ofcr_led_gate.sv
// One LED channel: LED drive from manual switch or sequencer mode
`timescale 1ns/100ps
`default_nettype none
module ofcr_led_gate (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Control
  input wire logic [1:0] channel,
  input wire logic man_mode,
  input wire logic direct_switch,
  input wire logic [2:0] iteration_mode,
  input wire logic seq_active,
  input wire logic seq_led_window,
  input wire logic [1:0] iteration,
  // Result
  output logic led_on
);
  logic timed_on;

  always_comb
  begin
    unique case (iteration_mode)
      ofcr_pkg::MODE_OFF: timed_on = 1'b0;
      ofcr_pkg::MODE_ON: timed_on = seq_active;
      ofcr_pkg::MODE_TIMED: timed_on = seq_led_window;
      ofcr_pkg::MODE_EVEN: timed_on = seq_led_window & ~iteration[0];
      ofcr_pkg::MODE_ODD: timed_on = seq_led_window & iteration[0];
      ofcr_pkg::MODE_QUARTER: timed_on = seq_led_window & (iteration == channel);
      // Codes 6 and 7 are undefined; keep the LED dark
      default: timed_on = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      led_on <= 1'b0;
    else if (man_mode)
      led_on <= direct_switch;
    else
      led_on <= timed_on;
  end
endmodule // ofcr_led_gate
`default_nettype wire

// >>> core/ofcr_regs.sv
// Top: APB register bank steering the optical front end
// What this block does
// - All four range fields share reserved-three encoding
// - Range codes select 25, 50, 100 mA
// - Four current bytes, current=(code+1)*scale/256
// - Bit 26 picks manual over sequencer control
// - Manual bit 23 clear shorts the integrator
// - Manual bits 22..19 drive LED outputs directly
// - Routing field pairs photodiodes with LEDs
// - Diode connect bits mask the routing field result
// - Bit 13 keeps ADC results for software
// - Per-LED mode: off, on, timed, even, odd
// - Mode five: every fourth iteration, staggered start
// - Bit 25 picks tristate over reference hold
// - Headroom flags write-set, hardware-cleared on dropout
// - Offset current is code times 10 nA
// - Bits 5..2 connect photodiodes to amplifier
// - Bits 1,0 connect external inputs to amplifier
// - Integration window from sequencer or manual bit
// - LED configuration bits 11..8 enable sinks
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ofcr_regs (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Sequencer timing from the analog sequencer
  input wire logic SEQ_ACTIVE,
  input wire logic SEQ_LED_WINDOW,
  input wire logic SEQ_ITG_WINDOW,
  input wire logic SEQ_ITERATION_STEP,
  input wire logic SEQ_DEMOD_ACTIVE,
  // Comparators, asynchronous to CLOCK
  input wire logic [3:0] SINK_DROPOUT,
  // LED sinks
  output logic [3:0] SINK_ENABLE,
  output logic [7:0] SINK_RANGE_CODES,
  output logic [31:0] SINK_CURRENT_CODES,
  output logic [3:0] LED_DRIVE,
  // Photo amplifier
  output logic INTEGRATE,
  output logic [3:0] DIODE_CONNECT,
  output logic [1:0] EXT_INPUT_CONNECT,
  output logic [7:0] OFFSET_CODE,
  output logic DEMOD_FORCE_REF,
  output logic DEMOD_TRISTATE,
  output logic [13:0] AMP_TRIM,
  output logic AMP_ENABLE,
  // ADC data path
  output logic ADC_DMA_ENABLE
);
  logic [31:0] led_range_reg;
  logic [31:0] led_curr_reg;
  logic [31:0] pd_cfg_reg;
  logic [31:0] amp_cfg_reg;
  logic [31:0] man_seq_reg;
  logic [3:0] headroom_reg;
  logic [3:0] headroom_next;
  logic [1:0] iteration_reg;
  logic [3:0] dropout_meta_reg;
  logic [3:0] dropout_sync_reg;
  logic step_meta_reg;
  logic step_sync_reg;
  logic step_seen_reg;
  logic [3:0] led_on;
  logic [3:0] diode_route;
  logic [31:0] rdata_next;
  logic setup;
  logic wr_en;
  logic hit;
  logic man_mode;
  logic [1:0] route;

  ////////////////////////////////////////////////////////////////////////
  // APB decode: zero wait states, answer in the access phase

  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PWRITE & PREADY;
  assign man_mode = man_seq_reg[ofcr_pkg::MAN_MODE_BIT];
  assign route = man_seq_reg[ofcr_pkg::ROUTING_LSB +: 2];

  always_comb
  begin
    hit = 1'b1;
    rdata_next = 32'h0000_0000;
    unique case (PADDR)
      ofcr_pkg::LED_RANGE_OFS: rdata_next = led_range_reg;
      ofcr_pkg::LED_CURR_OFS: rdata_next = led_curr_reg;
      ofcr_pkg::PD_CFG_OFS:
      begin
        rdata_next = pd_cfg_reg;
        rdata_next[ofcr_pkg::HEADROOM_LSB +: 4] = headroom_reg;
      end
      ofcr_pkg::AMP_CFG_OFS: rdata_next = amp_cfg_reg;
      ofcr_pkg::MAN_SEQ_OFS: rdata_next = man_seq_reg;
      ofcr_pkg::ITER_OFS: rdata_next = {30'h0000_0000, iteration_reg};
      ofcr_pkg::STATUS_OFS: rdata_next = {20'h0_0000, DIODE_CONNECT, LED_DRIVE, headroom_reg};
      default: hit = 1'b0;
    endcase
  end

  // Pulse PREADY in the access cycle, so each access takes two edges
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= setup;
      PSLVERR <= setup & ~hit;
    end
  end

  // Read data held until the next read setup
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      PRDATA <= 32'h0000_0000;
    else if (setup && !PWRITE)
      PRDATA <= rdata_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage registers, only listed bits kept

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      led_range_reg <= ofcr_pkg::LED_RANGE_RST;
    else if (wr_en && PADDR == ofcr_pkg::LED_RANGE_OFS)
      led_range_reg <= PWDATA & ofcr_pkg::LED_RANGE_MASK;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      led_curr_reg <= ofcr_pkg::LED_CURR_RST;
    else if (wr_en && PADDR == ofcr_pkg::LED_CURR_OFS)
      led_curr_reg <= PWDATA & ofcr_pkg::LED_CURR_MASK;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      pd_cfg_reg <= ofcr_pkg::PD_CFG_RST;
    else if (wr_en && PADDR == ofcr_pkg::PD_CFG_OFS)
      pd_cfg_reg <= PWDATA & ofcr_pkg::PD_CFG_MASK;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      amp_cfg_reg <= ofcr_pkg::AMP_CFG_RST;
    else if (wr_en && PADDR == ofcr_pkg::AMP_CFG_OFS)
      amp_cfg_reg <= PWDATA & ofcr_pkg::AMP_CFG_MASK;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      man_seq_reg <= ofcr_pkg::MAN_SEQ_RST;
    else if (wr_en && PADDR == ofcr_pkg::MAN_SEQ_OFS)
      man_seq_reg <= PWDATA & ofcr_pkg::MAN_SEQ_MASK;
  end

  ////////////////////////////////////////////////////////////////////////
  // Headroom flags: write one sets, synchronised dropout clears

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      dropout_meta_reg <= 4'h0;
      dropout_sync_reg <= 4'h0;
    end
    else
    begin
      dropout_meta_reg <= SINK_DROPOUT;
      dropout_sync_reg <= dropout_meta_reg;
    end
  end

  // Software write of one wins over a simultaneous dropout so arming is never lost
  always_comb
  begin
    headroom_next = headroom_reg & ~dropout_sync_reg;
    if (wr_en && PADDR == ofcr_pkg::PD_CFG_OFS)
      headroom_next = headroom_next | PWDATA[ofcr_pkg::HEADROOM_LSB +: 4];
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      headroom_reg <= 4'h0;
    else
      headroom_reg <= headroom_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Iteration counter, advanced on each sequencer step while active and not in manual mode

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      step_meta_reg <= 1'b0;
      step_sync_reg <= 1'b0;
      step_seen_reg <= 1'b0;
    end
    else
    begin
      step_meta_reg <= SEQ_ITERATION_STEP;
      step_sync_reg <= step_meta_reg;
      step_seen_reg <= step_sync_reg;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      iteration_reg <= 2'h0;
    else if (!SEQ_ACTIVE || man_mode)
      iteration_reg <= 2'h0;
    else if (step_sync_reg && !step_seen_reg)
      iteration_reg <= iteration_reg + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-LED gating

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_led
      ofcr_led_gate u_gate (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .channel(2'(ch)),
        .man_mode(man_mode),
        .direct_switch(man_seq_reg[ofcr_pkg::DIRECT_LED_LSB + ch]),
        .iteration_mode(man_seq_reg[1 + 3 * ch +: 3]),
        .seq_active(SEQ_ACTIVE & man_seq_reg[ofcr_pkg::SEQ_EN_BIT]),
        .seq_led_window(SEQ_LED_WINDOW & man_seq_reg[ofcr_pkg::SEQ_EN_BIT]),
        .iteration(iteration_reg),
        .led_on(led_on[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Photodiode routing

  always_comb
  begin
    unique case (ofcr_pkg::ofcr_route_e'(route))
      ofcr_pkg::OFCR_ROUTE_ALL: diode_route = 4'hf;
      ofcr_pkg::OFCR_ROUTE_OWN: diode_route = led_on;
      ofcr_pkg::OFCR_ROUTE_PAIR_AB: diode_route = {{2{led_on[1]}}, {2{led_on[0]}}};
      ofcr_pkg::OFCR_ROUTE_PAIR_AD: diode_route = {{2{led_on[3]}}, {2{led_on[0]}}};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all registered

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      SINK_ENABLE <= 4'h0;
      SINK_RANGE_CODES <= 8'h00;
      SINK_CURRENT_CODES <= 32'h0000_0000;
      LED_DRIVE <= 4'h0;
    end
    else
    begin
      SINK_ENABLE <= led_range_reg[ofcr_pkg::SINK_EN_LSB +: 4];
      // Range codes pass unchanged; the sink decodes 0/1/2 as 25/50/100 mA
      SINK_RANGE_CODES <= led_range_reg[7:0];
      SINK_CURRENT_CODES <= led_curr_reg;
      LED_DRIVE <= led_on;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      INTEGRATE <= 1'b0;
      DIODE_CONNECT <= 4'h0;
      EXT_INPUT_CONNECT <= 2'h0;
      OFFSET_CODE <= 8'h00;
      AMP_TRIM <= 14'h0000;
      AMP_ENABLE <= 1'b0;
    end
    else
    begin
      // Low keeps the capacitors shorted
      INTEGRATE <= man_mode ? man_seq_reg[ofcr_pkg::DIRECT_ITG_BIT] : SEQ_ITG_WINDOW;
      DIODE_CONNECT <= diode_route & pd_cfg_reg[ofcr_pkg::DIODE_LSB +: 4];
      EXT_INPUT_CONNECT <= pd_cfg_reg[ofcr_pkg::EXT_IN_LSB +: 2];
      OFFSET_CODE <= pd_cfg_reg[ofcr_pkg::OFFSET_LSB +: 8];
      AMP_TRIM <= amp_cfg_reg[13:0];
      AMP_ENABLE <= amp_cfg_reg[31];
    end
  end

  // Only one idle state is driven, never both
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      DEMOD_FORCE_REF <= 1'b0;
      DEMOD_TRISTATE <= 1'b0;
    end
    else
    begin
      DEMOD_FORCE_REF <= ~SEQ_DEMOD_ACTIVE & ~pd_cfg_reg[ofcr_pkg::DEMOD_TRI_BIT];
      DEMOD_TRISTATE <= ~SEQ_DEMOD_ACTIVE & pd_cfg_reg[ofcr_pkg::DEMOD_TRI_BIT];
    end
  end

  // Set bit leaves results in the data register for software
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      ADC_DMA_ENABLE <= 1'b0;
    else
      ADC_DMA_ENABLE <= ~man_seq_reg[ofcr_pkg::DMA_OFF_BIT];
  end
endmodule // ofcr_regs
`default_nettype wire

// >>> bench/ofcr_regs_sva.sv
// Checker: APB timing and register-to-port relations of the control bank
`timescale 1ns/100ps
`default_nettype none
module ofcr_regs_sva (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Watched outputs
  input wire logic [3:0] SINK_ENABLE,
  input wire logic [3:0] LED_DRIVE,
  input wire logic INTEGRATE,
  input wire logic [7:0] OFFSET_CODE,
  input wire logic DEMOD_FORCE_REF,
  input wire logic DEMOD_TRISTATE,
  input wire logic ADC_DMA_ENABLE
);
  logic setup, wr_acc, unmapped;
  logic [31:0] wd_reg;
  assign setup = PSEL && !PENABLE;
  assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
  assign unmapped = !(PADDR inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h20, 8'h50, 8'h54});
  // Last written word, held so derived outputs can be compared two or three cycles later
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      wd_reg <= 32'h0000_0000;
    else if (wr_acc)
      wd_reg <= PWDATA;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  AST_READY_AFTER_SETUP:
    assert property (setup |=> PREADY) else $error("no ready after setup");
  AST_READY_PULSE:
    assert property (PREADY |=> !PREADY) else $error("ready longer than a cycle");
  AST_ERR_UNMAPPED:
    assert property (setup |=> PSLVERR == $past(unmapped)) else $error("slave error wrong");
  AST_ERR_READ_ZERO:
    assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0) else $error("unmapped read nonzero");
  AST_SINK_ENABLE:
    assert property (wr_acc && PADDR == 8'h00 |=> ##1 SINK_ENABLE == wd_reg[11:8])
      else $error("sink enable mismatch");
  AST_OFFSET:
    assert property (wr_acc && PADDR == 8'h08 |=> ##1 OFFSET_CODE == wd_reg[15:8])
      else $error("offset code mismatch");
  AST_MAN_LED:
    assert property (wr_acc && PADDR == 8'h20 && PWDATA[26] |=> ##2 LED_DRIVE == wd_reg[22:19])
      else $error("direct led drive mismatch");
  AST_MAN_ITG:
    assert property (wr_acc && PADDR == 8'h20 && PWDATA[26] |=> ##1 INTEGRATE == wd_reg[23])
      else $error("direct integrate mismatch");
  AST_DMA:
    assert property (wr_acc && PADDR == 8'h20 |=> ##1 ADC_DMA_ENABLE == !wd_reg[13])
      else $error("dma enable mismatch");
  AST_DEMOD_EXCL:
    assert property (!(DEMOD_FORCE_REF && DEMOD_TRISTATE)) else $error("demod both idle states");
endmodule // ofcr_regs_sva
`default_nettype wire

// >>> bench/ofcr_regs_bench.sv
// Testbench: APB sequences and port checks of the control bank
`timescale 1ns/100ps
`default_nettype none
module ofcr_regs_bench;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, cur;
  logic sq_act, sq_win, sq_itg, sq_step, sq_dem, integ, fref, tri_st, amp_en, dma_en;
  logic [3:0] drop, sink_en, led, diode;
  logic [7:0] rng, offs;
  logic [1:0] ext;
  logic [13:0] trim;
  logic [7:0] ofs [0:4] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20};
  logic [31:0] rstv [0:4] = '{32'h55, 32'h0, 32'h0, 32'h3f00, 32'h0};
  logic [31:0] full [0:4] = '{32'h0004_0fff, 32'hffff_ffff, 32'h02f0_ff3f, 32'h8000_3fff,
    32'h04fe_3fff};
  logic [3:0] route [0:3] = '{4'hf, 4'h9, 4'h3, 4'hf};
  int bad_count, num_checks, cycles, i;
  ofcr_regs u_dut (.CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SEQ_ACTIVE(sq_act), .SEQ_LED_WINDOW(sq_win), .SEQ_ITG_WINDOW(sq_itg),
    .SEQ_ITERATION_STEP(sq_step), .SEQ_DEMOD_ACTIVE(sq_dem), .SINK_DROPOUT(drop),
    .SINK_ENABLE(sink_en), .SINK_RANGE_CODES(rng), .SINK_CURRENT_CODES(cur), .LED_DRIVE(led),
    .INTEGRATE(integ), .DIODE_CONNECT(diode), .EXT_INPUT_CONNECT(ext), .OFFSET_CODE(offs),
    .DEMOD_FORCE_REF(fref), .DEMOD_TRISTATE(tri_st), .AMP_TRIM(trim), .AMP_ENABLE(amp_en),
    .ADC_DMA_ENABLE(dma_en));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Entered and left just after a rising edge; one idle cycle between transfers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      complete_run();
    end
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {sq_act, sq_win, sq_itg, sq_step, sq_dem, drop} = '0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    for (i = 0; i < 5; i++)
      rchk(ofs[i], rstv[i]);
    for (i = 0; i < 5; i++)
    begin
      apb(1'b1, ofs[i], 32'hffff_ffff);
      rchk(ofs[i], full[i]);
    end
    repeat (3) @(posedge clock);
    chk(32'({sink_en, rng}), 32'h0fff);
    chk(cur, 32'hffff_ffff);
    chk(32'({offs, ext, amp_en, trim}), 32'h01ff_ffff);
    chk(32'({led, integ, dma_en, tri_st}), 32'h0000_007d);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    chk(32'(err), 32'h1);
    rchk(8'h10, 32'h0);
    apb(1'b1, 8'h08, 32'h00f0_003c);
    apb(1'b1, 8'h20, 32'h0450_0000);
    repeat (3) @(posedge clock);
    chk(32'({led, integ, fref, tri_st}), 32'h0000_0052);
    sq_dem <= 1'b1;
    drop <= 4'h2;
    repeat (6) @(posedge clock);
    chk(32'({fref, tri_st}), 32'h0);
    drop <= 4'h0;
    rchk(8'h08, 32'h00d0_003c);
    apb(1'b1, 8'h08, 32'h0000_003c);
    rchk(8'h08, 32'h00d0_003c);
    apb(1'b1, 8'h08, 32'h00f0_003c);
    rchk(8'h08, 32'h00f0_003c);
    {sq_act, sq_win, sq_itg} <= 3'b111;
    apb(1'b1, 8'h20, 32'h0000_16c7);
    for (i = 0; i < 4; i++)
    begin
      repeat (6) @(posedge clock);
      chk(32'(led), 32'({i == 3, i == 2, i % 2 == 1, i % 2 == 0}));
      rchk(8'h50, 32'(i));
      sq_step <= 1'b1;
      repeat (3) @(posedge clock);
      sq_step <= 1'b0;
    end
    chk(32'(integ), 32'h1);
    apb(1'b1, 8'h20, 32'h0000_1885);
    sq_itg <= 1'b0;
    repeat (4) @(posedge clock);
    chk(32'({led, integ}), 32'h0a);
    sq_win <= 1'b0;
    repeat (4) @(posedge clock);
    chk(32'(led), 32'h4);
    sq_win <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'h20, 32'h0000_0403 | (32'(i) << 17));
      repeat (4) @(posedge clock);
      chk(32'(diode), 32'(route[i]));
    end
    apb(1'b1, 8'h08, 32'h0000_001c);
    apb(1'b1, 8'h20, 32'h0000_0403);
    repeat (4) @(posedge clock);
    chk(32'(diode), 32'h7);
    rchk(8'h54, 32'h0000_079f);
    complete_run();
  end
endmodule // ofcr_regs_bench
bind ofcr_regs ofcr_regs_sva u_sva (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SINK_ENABLE(SINK_ENABLE), .LED_DRIVE(LED_DRIVE),
  .INTEGRATE(INTEGRATE), .OFFSET_CODE(OFFSET_CODE), .DEMOD_FORCE_REF(DEMOD_FORCE_REF),
  .DEMOD_TRISTATE(DEMOD_TRISTATE), .ADC_DMA_ENABLE(ADC_DMA_ENABLE));
`default_nettype wire
